// *** logic/pgr_unit.sv ***
// One peripheral's run enable, sleep gating, enable delay and reset pulse.
`timescale 1ns/1ns
`default_nettype none
module pgr_unit
    import pgr_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_present,
    input wire logic i_en_req,
    input wire logic i_dis_req,
    input wire logic i_rst_req,
    input wire logic i_slp_keep_req,
    input wire logic i_slp_stop_req,
    input wire logic i_sleeping,
    input wire logic i_gate_en,
    input wire logic i_access,
    output logic o_clk_en,
    output logic o_unit_rst,
    output logic o_ready,
    output logic o_fault,
    output logic o_run_en,
    output logic o_slp_en
);
    pgr_state_t state_q;
    logic [PGR_CNT_W-1:0] dly_q;
    logic [PGR_CNT_W-1:0] rst_cnt_q;

    // ************************************************************
    // Run enable with its enable delay.
    // ************************************************************
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            state_q <= PGR_OFF;
            dly_q <= PGR_CNT_ZERO;
        end
        else
        begin
            // The countdown runs on its own once started, so the selector may move on to another unit.
            case (state_q)
                PGR_OFF:
                begin
                    if (i_en_req && i_present)
                    begin
                        state_q <= PGR_WAKING;
                        dly_q <= PGR_CNT_W'(PGR_ENABLE_DELAY - 1);
                    end
                end
                PGR_WAKING:
                begin
                    if (i_dis_req && i_present)
                        state_q <= PGR_OFF;
                    else if (dly_q == PGR_CNT_ONE)
                        state_q <= PGR_ON;
                    dly_q <= dly_q - PGR_CNT_ONE;
                end
                PGR_ON:
                begin
                    if (i_dis_req && i_present)
                        state_q <= PGR_OFF;
                end
                default:
                    state_q <= PGR_OFF;
            endcase
        end
    end

    // ************************************************************
    // Sleep setting, kept stored regardless of the global gate.
    // ************************************************************
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
            o_slp_en <= 1'b0;
        else if (i_slp_keep_req && i_present)
            o_slp_en <= 1'b1;
        else if (i_slp_stop_req && i_present)
            o_slp_en <= 1'b0;
    end

    // Gating stops the clock only; register state is untouched, so the unit resumes where it was.
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            o_clk_en <= 1'b0;
            o_run_en <= 1'b0;
            o_ready <= 1'b0;
        end
        else
        begin
            o_run_en <= (state_q == PGR_ON);
            o_ready <= (state_q == PGR_ON);
            o_clk_en <= (state_q == PGR_ON) && (!(i_sleeping && i_gate_en) || o_slp_en);
        end
    end

    // Accesses outside the fully enabled state end in a fault.
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
            o_fault <= 1'b0;
        else
            o_fault <= i_access && (state_q != PGR_ON);
    end

    // ************************************************************
    // Software reset pulse; the enable state is not touched.
    // ************************************************************
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
            rst_cnt_q <= PGR_CNT_ZERO;
        else if (i_rst_req && i_present)
            rst_cnt_q <= PGR_CNT_W'(PGR_RESET_PULSE);
        else if (rst_cnt_q != PGR_CNT_ZERO)
            rst_cnt_q <= rst_cnt_q - PGR_CNT_ONE;
    end

    always_ff @(posedge i_clk)
    begin
        if (i_srst)
            o_unit_rst <= 1'b1;
        else
            o_unit_rst <= (rst_cnt_q != PGR_CNT_ZERO) || (i_rst_req && i_present);
    end

    a_enable_delay: assert property (@(posedge i_clk) disable iff (i_srst)
        (state_q == PGR_OFF && i_en_req && i_present && !i_dis_req) |->
        (!o_run_en && !o_ready) [*6] ##1 (o_run_en || $past(i_dis_req, 4) || $past(i_dis_req, 3) || $past(i_dis_req, 2)
        || $past(i_dis_req, 1) || $past(i_dis_req, 5) || $past(i_srst)))
        else $error("enable did not complete after five cycles");
    a_early_fault: assert property (@(posedge i_clk) disable iff (i_srst)
        (state_q == PGR_WAKING && i_access) |=> o_fault)
        else $error("access during enable delay did not fault");
    a_disabled_quiet: assert property (@(posedge i_clk) disable iff (i_srst)
        !o_run_en |-> !o_clk_en && !o_ready)
        else $error("disabled unit is clocked or answering");
    a_reset_pulse: assert property (@(posedge i_clk) disable iff (i_srst)
        (i_rst_req && i_present) |=> o_unit_rst [*5] ##1 (!o_unit_rst || $past(i_rst_req)))
        else $error("reset pulse wrong length");
    a_reset_keeps_en: assert property (@(posedge i_clk) disable iff (i_srst)
        (i_rst_req && !i_en_req && !i_dis_req) |=> $stable(state_q) || $past(state_q) == PGR_WAKING)
        else $error("reset changed enable state");
    a_sleep_gate: assert property (@(posedge i_clk) disable iff (i_srst)
        (i_sleeping && i_gate_en && !o_slp_en) |=> !o_clk_en)
        else $error("unit clocked while gated in sleep");
    a_no_gate: assert property (@(posedge i_clk) disable iff (i_srst)
        (!i_gate_en && state_q == PGR_ON) |=> o_clk_en)
        else $error("ungated unit stopped");
    a_absent_ignored: assert property (@(posedge i_clk) disable iff (i_srst)
        (!i_present && state_q != PGR_WAKING && rst_cnt_q == PGR_CNT_ZERO && !o_unit_rst) |=>
        $stable(state_q) && $stable(o_slp_en) && !o_unit_rst)
        else $error("absent unit reacted");
endmodule : pgr_unit
`default_nettype wire

// *** logic/pgr_pkg.sv ***
// Package of constants for the peripheral gating and reset controller.
package pgr_pkg;
    localparam int PGR_NUM_UNITS = 40;
    localparam int PGR_SEL_W = 6;
    localparam int PGR_ENABLE_DELAY = 5;
    localparam int PGR_RESET_PULSE = 4;
    localparam int PGR_CNT_W = 4;
    localparam logic [PGR_CNT_W-1:0] PGR_CNT_ZERO = 4'h0;
    localparam logic [PGR_CNT_W-1:0] PGR_CNT_ONE = 4'h1;
    localparam logic [63:0] PGR_PRESENT_DEFAULT = 64'h0000_00FF_FFFF_FFFF;
    typedef enum logic [1:0] {
        PGR_OFF,
        PGR_WAKING,
        PGR_ON
    } pgr_state_t;
endpackage : pgr_pkg

// *** logic/pgr_top.sv ***
// Top of the peripheral gating and reset controller.
`timescale 1ns/1ns
`default_nettype none
module pgr_top
    import pgr_pkg::*;
#(
    parameter int NUM_UNITS = PGR_NUM_UNITS,
    parameter logic [63:0] PRESENT_MASK = PGR_PRESENT_DEFAULT
)
(
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic [PGR_SEL_W-1:0] i_unit_selector,
    input wire logic i_run_enable_request,
    input wire logic i_run_disable_request,
    input wire logic i_unit_soft_reset_request,
    input wire logic i_unit_presence_query,
    input wire logic i_sleep_stop_request,
    input wire logic i_sleep_keep_running_request,
    input wire logic i_global_sleep_gating_enable,
    input wire logic i_sleeping,
    input wire logic [NUM_UNITS-1:0] i_unit_access,
    output logic o_presence_valid,
    output logic o_presence,
    output logic [NUM_UNITS-1:0] o_unit_clk_en,
    output logic [NUM_UNITS-1:0] o_unit_rst,
    output logic [NUM_UNITS-1:0] o_unit_ready,
    output logic [NUM_UNITS-1:0] o_unit_fault,
    output logic [NUM_UNITS-1:0] o_run_en,
    output logic [NUM_UNITS-1:0] o_sleep_en,
    output logic o_wake
);
    initial
    begin
        if (NUM_UNITS < 1 || NUM_UNITS > (1 << PGR_SEL_W) || NUM_UNITS > 64)
            $error("NUM_UNITS out of range");
    end

    // ************************************************************
    // Request decode, one unit at a time.
    // ************************************************************
    logic [NUM_UNITS-1:0] sel_hit;
    logic gate_q;
    logic [NUM_UNITS-1:0] run_keep;

    always_ff @(posedge i_clk)
    begin
        if (i_srst)
            gate_q <= 1'b0;
        else
            gate_q <= i_global_sleep_gating_enable;
    end

    genvar g;
    generate
        for (g = 0; g < NUM_UNITS; g++)
        begin : g_unit
            assign sel_hit[g] = (i_unit_selector == PGR_SEL_W'(g));
            assign run_keep[g] = o_run_en[g] && o_sleep_en[g];
            pgr_unit u_unit (
                .i_clk(i_clk),
                .i_srst(i_srst),
                .i_present(PRESENT_MASK[g] && sel_hit[g]),
                .i_en_req(i_run_enable_request),
                .i_dis_req(i_run_disable_request),
                .i_rst_req(i_unit_soft_reset_request),
                .i_slp_keep_req(i_sleep_keep_running_request),
                .i_slp_stop_req(i_sleep_stop_request),
                .i_sleeping(i_sleeping),
                .i_gate_en(gate_q),
                .i_access(i_unit_access[g]),
                .o_clk_en(o_unit_clk_en[g]),
                .o_unit_rst(o_unit_rst[g]),
                .o_ready(o_unit_ready[g]),
                .o_fault(o_unit_fault[g]),
                .o_run_en(o_run_en[g]),
                .o_slp_en(o_sleep_en[g])
            );
        end
    endgenerate

    // ************************************************************
    // Presence answer and wake path.
    // ************************************************************
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            o_presence_valid <= 1'b0;
            o_presence <= 1'b0;
        end
        else
        begin
            o_presence_valid <= i_unit_presence_query;
            o_presence <= i_unit_presence_query && (32'(i_unit_selector) < NUM_UNITS)
                && PRESENT_MASK[i_unit_selector];
        end
    end

    // Only units that keep running in sleep may raise a wake; the unit's own event is not seen here.
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
            o_wake <= 1'b0;
        else
            o_wake <= i_sleeping && |(run_keep & i_unit_access);
    end

    a_presence_ans: assert property (@(posedge i_clk) disable iff (i_srst)
        i_unit_presence_query |=> o_presence_valid && (o_presence == ((32'($past(i_unit_selector)) < NUM_UNITS)
        && PRESENT_MASK[$past(i_unit_selector)])))
        else $error("presence answer wrong");
    a_start_off: assert property (@(posedge i_clk)
        $past(i_srst) |-> o_run_en == '0)
        else $error("unit enabled out of reset");
endmodule : pgr_top
`default_nettype wire

// *** dv/pgr_periph_model.sv ***
// Behavioural peripheral whose counter stands for its internal state.
`timescale 1ns/1ns
`default_nettype none
module pgr_periph_model
(
    input wire logic i_clk,
    input wire logic i_clk_en,
    input wire logic i_unit_rst,
    output logic [7:0] o_count
);
    // Only the gated enable and the unit reset move the state, so a stopped unit keeps it whole unless reset.
    always_ff @(posedge i_clk)
    begin
        if (i_unit_rst)
        begin
            o_count <= 8'h00;
        end
        else if (i_clk_en)
        begin
            o_count <= o_count + 8'h01;
        end
    end
endmodule : pgr_periph_model
`default_nettype wire

// *** dv/pgr_top_bench.sv ***
// Self-checking bench for the peripheral gating and reset controller.
`timescale 1ns/1ns
`default_nettype none
module pgr_top_bench import pgr_pkg::*;;
    localparam int NU = 8;
    logic clk, srst, gate, slp, pv, pres, wake;
    logic [PGR_SEL_W-1:0] sel;
    logic [5:0] rq;
    logic [NU-1:0] acc, cke, urst, rdy, flt, run, sen;
    logic [7:0] pcnt [NU];
    logic [7:0] save;
    int err_total;
    int cmp_count;
    int cycles = 0;
    // Unit 7 is left out of the mask so that absent-unit requests can be tried.
    pgr_top #(.NUM_UNITS(NU), .PRESENT_MASK(64'h0000_0000_0000_007F)) dut (
        .i_clk(clk), .i_srst(srst), .i_unit_selector(sel),
        .i_run_enable_request(rq[0]), .i_run_disable_request(rq[1]),
        .i_unit_soft_reset_request(rq[2]), .i_unit_presence_query(rq[3]),
        .i_sleep_stop_request(rq[4]), .i_sleep_keep_running_request(rq[5]),
        .i_global_sleep_gating_enable(gate), .i_sleeping(slp), .i_unit_access(acc),
        .o_presence_valid(pv), .o_presence(pres), .o_unit_clk_en(cke), .o_unit_rst(urst),
        .o_unit_ready(rdy), .o_unit_fault(flt), .o_run_en(run), .o_sleep_en(sen), .o_wake(wake));
    for (genvar g = 0; g < NU; g++)
    begin : g_per
        pgr_periph_model u_m (.i_clk(clk), .i_clk_en(cke[g]), .i_unit_rst(urst[g]), .o_count(pcnt[g]));
    end
    // ****************************************
    // Helpers
    // ****************************************
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // Returns in the time step of the edge that takes the request.
    task automatic req(input int k, input int u);
        @(posedge clk);
        sel <= u[PGR_SEL_W-1:0];
        rq <= 6'h01 << k;
        @(posedge clk);
        rq <= 6'h00;
    endtask : req
    task automatic hit(input int u);
        @(posedge clk);
        acc <= 8'h01 << u;
        @(posedge clk);
        acc <= 8'h00;
        #1;
    endtask : hit
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : close_out
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_start();
        tick(2);
        chk(run, 8'h00);
        chk(cke, 8'h00);
        hit(1);
        chk(flt, 8'h02);
        req(0, 7);
        req(2, 7);
        req(5, 7);
        tick(8);
        chk(run | rdy | urst | sen, 8'h00);
        req(3, 7);
        #1 chk({6'h00, pv, pres}, 8'h02);
        req(3, 2);
        #1 chk({6'h00, pv, pres}, 8'h03);
        $display("start test done");
    endtask : t_start
    task automatic t_enable();
        req(0, 2);
        hit(2);
        chk(flt, 8'h04);
        tick(2);
        chk(rdy, 8'h00);
        tick(1);
        chk(rdy & run & cke, 8'h04);
        // Normal traffic waits until the unit reports ready.
        hit(2);
        chk(flt, 8'h00);
        $display("enable test done");
    endtask : t_enable
    task automatic t_soft_reset();
        req(2, 2);
        for (int i = 1; i <= 6; i++)
        begin
            #1 chk(urst, (i < 6) ? 8'h04 : 8'h00);
            @(posedge clk);
        end
        tick(2);
        chk(run, 8'h04);
        chk({7'h00, pcnt[2] != 8'h00 && pcnt[2] < 8'h05}, 8'h01);
        $display("soft reset test done");
    endtask : t_soft_reset
    task automatic t_sleep();
        req(0, 3);
        tick(7);
        req(5, 3);
        req(4, 2);
        tick(1);
        chk(sen, 8'h08);
        slp <= 1'b1;
        tick(3);
        chk(cke, 8'h0C);
        gate <= 1'b1;
        tick(3);
        chk(cke, 8'h08);
        save = pcnt[2];
        tick(4);
        chk(pcnt[2], save);
        hit(3);
        chk({7'h00, wake}, 8'h01);
        slp <= 1'b0;
        tick(3);
        chk(cke & run, 8'h0C);
        chk({7'h00, pcnt[2] > save && pcnt[2] < save + 8'h05}, 8'h01);
        gate <= 1'b0;
        $display("sleep test done");
    endtask : t_sleep
    task automatic t_disable();
        req(1, 2);
        tick(7);
        chk(run & cke & rdy, 8'h08);
        hit(2);
        chk(flt, 8'h04);
        $display("disable test done");
    endtask : t_disable
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // The whole run needs about 90 cycles.
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 3000)
        begin
            err_total++;
            close_out();
        end
    end
    initial
    begin
        srst = 1'b1;
        sel = '0;
        rq = 6'h00;
        gate = 1'b0;
        slp = 1'b0;
        acc = 8'h00;
        err_total = 0;
        cmp_count = 0;
        repeat (8) @(posedge clk);
        srst <= 1'b0;
        t_start();
        t_enable();
        t_soft_reset();
        t_sleep();
        t_disable();
        close_out();
    end
endmodule : pgr_top_bench
`default_nettype wire
